// file: logic/quad_dac_cfg.svh
// constants for the quad converter bus interface
`ifndef QUAD_DAC_CFG_SVH
`define QUAD_DAC_CFG_SVH
`define CHAN_COUNT 4
`define BYTE_COUNT 8
`define VALUE_BITS 12
`define LOW_BITS 8
`define HIGH_BITS 4
`define SEL_BITS 3
`define BASE_ADDR_RESET 8'h00
// identity code value is arbitrary
`define GENERIC_CODE 8'h5a
`define RAM_RESET 8'h00
`endif

// file: logic/quad_dac_pkg.sv
// types for the quad converter bus interface
package quad_dac_pkg;
	typedef struct packed {
		logic generic_code_select;
		logic test_exercise_select;
		logic clear_outputs_bit;
		logic disable_outputs_bit;
	} ctrl_bits_t;
	typedef struct packed {
		logic [3:0] load_upper_strobe;
		logic [3:0] load_lower_strobe;
		logic [7:0] data;
	} iso_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ADDRESSED = 3'b010,
		ST_STROBE = 3'b100
	} bus_state_t;
endpackage

// file: logic/readback_ram.sv
// eight-byte read-back store, changed only by writes
`timescale 1ns/100ps
`include "quad_dac_cfg.svh"
module readback_ram (
	// clock
	input wire logic clk_in,
	// access
	input wire logic wr_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_r [0:`BYTE_COUNT-1];
	logic [7:0] mem_nxt [0:`BYTE_COUNT-1];
	genvar i;
	generate
		for (i = 0; i < `BYTE_COUNT; i++) begin : g_byte
			always_comb begin
				mem_nxt[i] = mem_r[i];
				if (wr_in && addr_in == 3'(i)) begin
					mem_nxt[i] = wdata_in;
				end
			end
			// no reset: contents survive reset and clear
			always_ff @(posedge clk_in) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	endgenerate
	assign rdata_out = mem_r[addr_in];
endmodule

// file: logic/dac_channel_regs.sv
// isolated-side holding and output registers of one channel
`timescale 1ns/100ps
`include "quad_dac_cfg.svh"
module dac_channel_regs (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// control
	input wire logic zero_in,
	input wire logic load_upper_in,
	input wire logic load_lower_in,
	input wire logic [7:0] data_in,
	// output
	output logic [11:0] value_out
);
	logic [3:0] hold_r;
	logic [3:0] hold_nxt;
	logic [11:0] out_r;
	logic [11:0] out_nxt;
	always_comb begin
		hold_nxt = hold_r;
		out_nxt = out_r;
		if (load_upper_in) begin
			hold_nxt = data_in[3:0];
		end
		if (zero_in) begin
			out_nxt = 12'h000;
		end else if (load_lower_in) begin
			out_nxt = {hold_r, data_in};
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hold_r <= 4'h0;
			out_r <= 12'h000;
		end else begin
			hold_r <= hold_nxt;
			out_r <= out_nxt;
		end
	end
	assign value_out = out_r;
endmodule

// file: logic/quad_dac_bus_interface.sv
// bus-side control of the four-channel 12-bit converter module
// Summary of operation
// R01: eight consecutive byte addresses, low and high per channel.
// R02: every written byte also stored in the read-back RAM.
// R03: low byte holds bits 7:0, high byte bits 3:0 hold bits 11:8.
// R04: high-byte upper nibble reads back but never reaches outputs.
// R05: generic select makes all eight addresses read the identity code.
// R06: own address asserts module selected and latches three select bits.
// R07: select bits address RAM and decode to upper or lower load strobes.
// R08: strobes accepted only after the addressing phase.
// R09: write updates RAM with channel register; reads return RAM.
// R10: test bit: writes reach RAM only, outputs unchanged.
// R11: clear or disable zeroes outputs unless retentive; RAM kept.
// R12: outputs stay zero after clear until the channel is rewritten.
// R13: clear, disable and initialize never alter the RAM.
// R14: high byte goes to holding register without changing output.
// R15: low write loads eight low and four held bits at once.
// R16: each channel has its own holding register.
// R17: all transfers are started by the processor side.
// R18: bus initialize zeroes outputs in the standard configuration.
// R19: retentive option: disable and initialize leave outputs alone.
// R20: low write alone uses whatever the holding register has.
`timescale 1ns/100ps
`include "quad_dac_cfg.svh"
module quad_dac_bus_interface #(
	parameter logic RETENTIVE = 1'b0,
	// identity code value is arbitrary
	parameter logic [7:0] GENERIC_CODE = `GENERIC_CODE
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// bus addressing and strobes
	input wire logic bus_init_in,
	input wire logic addr_valid_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] base_addr_in,
	input wire logic write_cycle_in,
	input wire logic read_cycle_in,
	input wire logic [7:0] wdata_in,
	input wire quad_dac_pkg::ctrl_bits_t ctrl_in,
	// bus answers
	output logic module_selected_out,
	output logic [2:0] byte_select_out,
	output logic [7:0] rdata_out,
	output logic reply_out,
	// converter values
	output logic [47:0] chan_value_out
);
	import quad_dac_pkg::*;

	// two-flop sync of bus pins; logic reads only the second stage
	logic [1:0] av_s_r;
	logic [1:0] av_s_nxt;
	logic [1:0] wr_s_r;
	logic [1:0] wr_s_nxt;
	logic [1:0] rd_s_r;
	logic [1:0] rd_s_nxt;
	logic [1:0] init_s_r;
	logic [1:0] init_s_nxt;
	// address and data ride alongside their qualifiers
	logic [7:0] addr_s0_r;
	logic [7:0] addr_s0_nxt;
	logic [7:0] addr_s1_r;
	logic [7:0] addr_s1_nxt;
	logic [7:0] wdat_s0_r;
	logic [7:0] wdat_s0_nxt;
	logic [7:0] wdat_s1_r;
	logic [7:0] wdat_s1_nxt;
	always_comb begin
		av_s_nxt = {av_s_r[0], addr_valid_in};
		wr_s_nxt = {wr_s_r[0], write_cycle_in};
		rd_s_nxt = {rd_s_r[0], read_cycle_in};
		init_s_nxt = {init_s_r[0], bus_init_in};
		addr_s0_nxt = addr_in;
		addr_s1_nxt = addr_s0_r;
		wdat_s0_nxt = wdata_in;
		wdat_s1_nxt = wdat_s0_r;
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			av_s_r <= 2'b00;
			wr_s_r <= 2'b00;
			rd_s_r <= 2'b00;
			init_s_r <= 2'b00;
			addr_s0_r <= 8'h00;
			addr_s1_r <= 8'h00;
			wdat_s0_r <= 8'h00;
			wdat_s1_r <= 8'h00;
		end else begin
			av_s_r <= av_s_nxt;
			wr_s_r <= wr_s_nxt;
			rd_s_r <= rd_s_nxt;
			init_s_r <= init_s_nxt;
			addr_s0_r <= addr_s0_nxt;
			addr_s1_r <= addr_s1_nxt;
			wdat_s0_r <= wdat_s0_nxt;
			wdat_s1_r <= wdat_s1_nxt;
		end
	end

	// base address switches pass two flops as well
	logic [7:0] base_s0_r;
	logic [7:0] base_s0_nxt;
	logic [7:0] base_s1_r;
	logic [7:0] base_s1_nxt;
	always_comb begin
		base_s0_nxt = base_addr_in;
		base_s1_nxt = base_s0_r;
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			base_s0_r <= `BASE_ADDR_RESET;
			base_s1_r <= `BASE_ADDR_RESET;
		end else begin
			base_s0_r <= base_s0_nxt;
			base_s1_r <= base_s1_nxt;
		end
	end

	logic av_q;
	logic wr_q;
	logic rd_q;
	logic init_q;
	logic [7:0] addr_q;
	logic [7:0] wdat_q;
	assign av_q = av_s_r[1];
	assign wr_q = wr_s_r[1];
	assign rd_q = rd_s_r[1];
	assign init_q = init_s_r[1];
	assign addr_q = addr_s1_r;
	assign wdat_q = wdat_s1_r;

	bus_state_t state_r;
	bus_state_t state_nxt;
	logic sel_r;
	logic sel_nxt;
	logic [2:0] bsel_r;
	logic [2:0] bsel_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic reply_r;
	logic reply_nxt;
	logic ram_wr;
	logic [7:0] ram_rdata;
	logic [3:0] ld_up;
	logic [3:0] ld_lo;
	logic hit;
	logic zero;

	// address match on the synchronised address
	assign hit = addr_q_hit(addr_q, base_s1_r); // R01

	function automatic logic addr_q_hit(input logic [7:0] a,
		input logic [7:0] b);
		addr_q_hit = (a[7:3] == b[7:3]);
	endfunction

	// per-channel decode of the latched byte select
	logic [3:0] chan_hit;
	genvar d;
	generate
		for (d = 0; d < `CHAN_COUNT; d++) begin : g_dec
			assign chan_hit[d] = (bsel_r[2:1] == 2'(d)); // R07
		end
	endgenerate

	// strobes are taken only after the address phase has ended
	logic take_wr;
	logic take_rd;
	logic strobe_gone;
	logic wr_now;
	logic rd_now;
	assign take_wr = !av_q && wr_q; // R08
	assign take_rd = !av_q && rd_q; // R08
	assign strobe_gone = !wr_q && !rd_q;
	assign wr_now = (state_r == ST_ADDRESSED) && take_wr;
	assign rd_now = (state_r == ST_ADDRESSED) && !take_wr && take_rd;

	// transfer sequencing
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (av_q && hit) begin
					state_nxt = ST_ADDRESSED;
				end
			end
			ST_ADDRESSED: begin
				if (take_wr || take_rd) begin
					state_nxt = ST_STROBE;
				end else if (av_q && !hit) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_STROBE: begin
				if (strobe_gone) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// module selection and latched byte select
	always_comb begin
		sel_nxt = sel_r;
		bsel_nxt = bsel_r;
		unique case (state_r)
			ST_IDLE: begin
				sel_nxt = av_q && hit; // R06
				if (av_q && hit) begin
					bsel_nxt = addr_q[2:0]; // R06
				end
			end
			ST_ADDRESSED: begin
				sel_nxt = 1'b1;
			end
			ST_STROBE: begin
				if (strobe_gone) begin
					sel_nxt = 1'b0;
				end
			end
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sel_r <= 1'b0;
			bsel_r <= 3'h0;
		end else begin
			sel_r <= sel_nxt;
			bsel_r <= bsel_nxt;
		end
	end

	// write path: read-back store always, channel strobes unless testing
	always_comb begin
		ram_wr = wr_now; // R02 R09 R13
		ld_up = 4'h0;
		ld_lo = 4'h0;
		if (wr_now && !ctrl_in.test_exercise_select) begin // R10
			ld_up = chan_hit & {4{bsel_r[0]}}; // R07 R14 R16
			ld_lo = chan_hit & {4{!bsel_r[0]}}; // R07 R15 R16
		end
	end

	// read data: identity code or read-back contents
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_now) begin
			if (ctrl_in.generic_code_select) begin
				rdata_nxt = GENERIC_CODE; // R05
			end else begin
				rdata_nxt = ram_rdata; // R09 R04
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// reply stands from acceptance until the strobe is gone
	always_comb begin
		reply_nxt = wr_now || rd_now;
		if (state_r == ST_STROBE && !strobe_gone) begin
			reply_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			reply_r <= 1'b0;
		end else begin
			reply_r <= reply_nxt;
		end
	end

	// clear, disable and initialize zero outputs unless retentive
	logic zero_r;
	logic zero_nxt;
	always_comb begin
		zero_nxt = !RETENTIVE && (ctrl_in.clear_outputs_bit
			|| ctrl_in.disable_outputs_bit || init_q); // R11 R18 R19
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			zero_r <= 1'b0;
		end else begin
			zero_r <= zero_nxt;
		end
	end
	assign zero = zero_r;

	readback_ram u_ram (
		.clk_in(clk_in),
		.wr_in(ram_wr),
		.addr_in(bsel_r),
		.wdata_in(wdat_q),
		.rdata_out(ram_rdata)
	);

	// command word carried across the isolation, one cycle late
	iso_cmd_t iso_cmd_r;
	iso_cmd_t iso_cmd_nxt;
	always_comb begin
		iso_cmd_nxt.load_upper_strobe = ld_up; // R07
		iso_cmd_nxt.load_lower_strobe = ld_lo; // R07
		iso_cmd_nxt.data = iso_cmd_r.data;
		if (wr_now) begin
			iso_cmd_nxt.data = wdat_q; // R03
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			iso_cmd_r <= '0;
		end else begin
			iso_cmd_r <= iso_cmd_nxt;
		end
	end

	logic [47:0] chan_value;
	genvar c;
	generate
		for (c = 0; c < `CHAN_COUNT; c++) begin : g_chan
			dac_channel_regs u_chan (
				.clk_in(clk_in),
				.reset_in(reset_in),
				.zero_in(zero), // R12
				.load_upper_in(iso_cmd_r.load_upper_strobe[c]),
				.load_lower_in(iso_cmd_r.load_lower_strobe[c]), // R20
				.data_in(iso_cmd_r.data), // R03
				.value_out(chan_value[c*12 +: 12])
			);
		end
	endgenerate

	assign module_selected_out = sel_r;
	assign byte_select_out = bsel_r;
	assign rdata_out = rdata_r;
	assign reply_out = reply_r;
	assign chan_value_out = chan_value;
endmodule

// file: testbench/quad_dac_chk_sva.sv
// port assertions for the converter bus interface
`timescale 1ns/100ps
`include "quad_dac_cfg.svh"
module quad_dac_chk #(
	parameter logic RETENTIVE = 1'b0
) (
	input wire logic clk_in, reset_in, addr_valid_in,
	input wire logic write_cycle_in, read_cycle_in,
	input wire logic [7:0] addr_in, base_addr_in, rdata_out,
	input wire quad_dac_pkg::ctrl_bits_t ctrl_in,
	input wire logic module_selected_out, reply_out,
	input wire logic [2:0] byte_select_out,
	input wire logic [47:0] chan_value_out
);
	import quad_dac_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_hit; $rose(module_selected_out) |->
		addr_in[7:3] == base_addr_in[7:3]; endproperty
	a_hit: assert property (p_hit) else $error("bad hit");
	property p_latch; $rose(module_selected_out) |->
		byte_select_out == addr_in[2:0]; endproperty
	a_latch: assert property (p_latch) else $error("bad select");
	property p_order; $rose(reply_out) |->
		!addr_valid_in && module_selected_out; endproperty
	a_order: assert property (p_order) else $error("early reply");
	property p_gen; $rose(reply_out) && read_cycle_in &&
		ctrl_in.generic_code_select |-> ##[0:1] rdata_out == `GENERIC_CODE;
	endproperty
	a_gen: assert property (p_gen) else $error("bad code");
	property p_test; ctrl_in == 4'b0100 |=> $stable(chan_value_out);
	endproperty
	a_test: assert property (p_test) else $error("output moved");
	property p_clr; (ctrl_in.clear_outputs_bit ||
		ctrl_in.disable_outputs_bit) && !RETENTIVE |->
		##[0:4] chan_value_out == '0; endproperty
	a_clr: assert property (p_clr) else $error("not cleared");
	property p_quiet; $changed(chan_value_out) |->
		(reply_out && !byte_select_out[0]) || chan_value_out == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stray load");
	property p_rel; reply_out && !write_cycle_in && !read_cycle_in |->
		##[1:6] !reply_out; endproperty
	a_rel: assert property (p_rel) else $error("reply stuck");
endmodule
bind quad_dac_bus_interface quad_dac_chk #(.RETENTIVE(RETENTIVE)) u_chk (.*);

// file: testbench/bus_host_model.sv
// processor-side host issuing one byte transfer at a time
`timescale 1ns/100ps
module bus_host_model (
	input wire logic clk_in, reply_in,
	input wire logic [7:0] rdata_in,
	output logic addr_valid_out, write_out, read_out,
	output logic [7:0] addr_out, wdata_out
);
	int stuck = 0;
	initial {addr_valid_out, write_out, read_out, addr_out, wdata_out} = '0;
	// a[8] set means write; address phase ends in the same cycle the strobe starts
	task automatic xfer(input logic [8:0] a, input logic [7:0] d,
		output logic hit, output logic [7:0] q);
		int n;
		addr_out <= a[7:0];
		addr_valid_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		addr_out <= ~a[7:0];
		addr_valid_out <= 1'b0;
		write_out <= a[8];
		read_out <= !a[8];
		wdata_out <= d;
		for (n = 0; n < 12 && reply_in !== 1'b1; n++) @(posedge clk_in);
		hit = reply_in;
		q = rdata_in;
		write_out <= 1'b0;
		read_out <= 1'b0;
		wdata_out <= ~d;
		for (n = 0; n < 12 && reply_in !== 1'b0; n++) @(posedge clk_in);
		if (reply_in !== 1'b0) stuck++;
		@(posedge clk_in);
	endtask
endmodule

// file: testbench/quad_dac_bus_interface_tb.sv
// self-checking bench for the converter bus interface
`timescale 1ns/100ps
`include "quad_dac_cfg.svh"
module quad_dac_bus_interface_tb;
	import quad_dac_pkg::*;
	localparam logic [7:0] BASE = 8'h28;
	logic clk_in = 0, reset_in = 1, bus_init_in = 0, hit;
	logic addr_valid_in, write_cycle_in, read_cycle_in;
	logic module_selected_out, reply_out;
	logic [7:0] addr_in, wdata_in, rdata_out, q;
	logic [2:0] byte_select_out;
	logic [47:0] chan_value_out;
	logic rt_sel, rt_reply;
	logic [7:0] rt_rdata;
	logic [2:0] rt_bsel;
	logic [47:0] rt_chan;
	logic [11:0] exr [4];
	logic [11:0] ex [4];
	logic [3:0] hold [4];
	logic [7:0] ram [8];
	ctrl_bits_t ctrl_in = '0;
	int miscompares = 0, n_tests = 0;
	quad_dac_bus_interface DUT (.*, .base_addr_in(BASE));
	quad_dac_bus_interface #(.RETENTIVE(1'b1)) DUT_RET (.clk_in, .reset_in,
		.bus_init_in, .addr_valid_in, .addr_in, .base_addr_in(BASE),
		.write_cycle_in, .read_cycle_in, .wdata_in, .ctrl_in,
		.module_selected_out(rt_sel), .byte_select_out(rt_bsel),
		.rdata_out(rt_rdata), .reply_out(rt_reply), .chan_value_out(rt_chan));
	bus_host_model host (.clk_in, .reply_in(reply_out),
		.rdata_in(rdata_out), .addr_valid_out(addr_valid_in),
		.write_out(write_cycle_in), .read_out(read_cycle_in),
		.addr_out(addr_in), .wdata_out(wdata_in));
	initial forever #4 clk_in = ~clk_in;
	task check(input logic [11:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] s, input logic [7:0] d);
		host.xfer({1'b1, BASE[7:3], s}, d, hit, q);
		check(12'(hit), 12'h1);
		check(12'(byte_select_out), 12'(s));
		check(12'(rt_bsel), 12'(s));
		check(12'({module_selected_out, reply_out, rt_sel, rt_reply}), 12'h0);
		ram[s] = d;
		if (!ctrl_in.test_exercise_select) begin
			if (s[0]) hold[s[2:1]] = d[3:0];
			else ex[s[2:1]] = {hold[s[2:1]], d};
			if (!s[0]) exr[s[2:1]] = ex[s[2:1]];
		end
	endtask
	task rd(input logic [2:0] s, input logic [7:0] e);
		host.xfer({1'b0, BASE[7:3], s}, 8'h00, hit, q);
		check(12'(hit), 12'h1);
		check(12'(q), 12'(e));
		check(12'(rt_rdata), 12'(e));
	endtask
	task chans;
		for (int c = 0; c < 4; c++) begin
			check(chan_value_out[12*c+:12], ex[c]);
			check(rt_chan[12*c+:12], exr[c]);
		end
	endtask
	task give_verdict;
		if (miscompares == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 0;
		@(posedge clk_in);
		ex = '{default: 12'h0};
		exr = '{default: 12'h0};
		hold = '{default: 4'h0};
		for (int s = 0; s < 8; s++) begin
			wr(3'(s ^ 1), 8'(8'h13 * s + 8'h21));
			chans;
		end
		wr(3'h0, 8'hc3);
		chans;
		for (int s = 0; s < 8; s++) rd(3'(s), ram[s]);
		host.xfer({1'b1, BASE + 8'h08}, 8'hff, hit, q);
		check(12'(hit), 12'h0);
		ctrl_in.test_exercise_select <= 1;
		wr(3'h5, 8'h0e);
		wr(3'h4, 8'h77);
		chans;
		rd(3'h4, 8'h77);
		ctrl_in <= 4'b1000;
		for (int s = 0; s < 8; s++) rd(3'(s), `GENERIC_CODE);
		for (int k = 0; k < 3; k++) begin
			ctrl_in <= {2'b00, k == 0, k == 1};
			bus_init_in <= (k == 2);
			repeat (8) @(posedge clk_in);
			ex = '{default: 12'h0};
			chans;
			ctrl_in <= '0;
			bus_init_in <= 0;
			repeat (8) @(posedge clk_in);
			chans;
			for (int s = 0; s < 8; s++) rd(3'(s), ram[s]);
			wr(3'h3, 8'h0a);
			wr(3'h2, 8'h5c);
			chans;
		end
		check(12'(host.stuck), 12'h0);
		give_verdict;
	end
endmodule
